// ---- logic/pms_status.sv ----
// Status word, latched faults, alert and store/restore of configuration
//
// Contract
// - Store copies every config register to NVM
// - Store accepted while running; bus may stall
// - Restore loads every config register from NVM
// - Restore accepted while running; bus may stall
// - Word read returns status; byte read low
// - Raw bits follow their condition live
// - Flags latch and hold until cleared
// - Unsupported status positions always read zero
// - Low bit 6 high while output unpowered
// - Low bit 5 latches output overvoltage
// - Low bit 4 latches output overcurrent
// - Low bit 3 latches input undervoltage
// - Low bit 2 latches over-temperature
// - Low bit 1 latches communication/logic fault
// - High bits 7..5 latch summary faults
// - High bit 3 reads inverted power-good pin
// - Flags clear only by three events
// - Clearing with fault present sets again
// - Alert asserted whenever a flag sets
// - Clear-faults command clears flags, releases alert
// - Unsupported command sets CML and alert
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.svh"

module pms_status #(
    parameter int CFG_N = `PMS_CFG_N
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  cmd_valid,
    output var  logic                  cmd_ready,
    input  wire pms_pkg::pms_kind_t    cmd_kind,
    input  wire logic [7:0]            cmd_code,
    input  wire logic [7:0]            cmd_wdata,
    output var  logic                  rd_valid,
    output var  logic [15:0]           rd_data,
    input  wire logic                  cond_vout_ov,
    input  wire logic                  cond_iout_oc,
    input  wire logic                  cond_vin_uv,
    input  wire logic                  cond_over_temp,
    input  wire logic                  cond_conv_off,
    input  wire logic                  power_good_pin,
    input  wire logic                  conv_enable_cmd,
    output var  logic                  alert_pin_out,
    output var  logic                  alert_pin_oe,
    output var  logic [CFG_N*8-1:0]    cfg_op
);

    pms_pkg::pms_regs_t        r;
    pms_pkg::pms_regs_t        n;
    logic                      take;
    logic                      clr;
    logic                      unsup;
    logic                      cfg_hit;
    logic [7:0]                cfg_off8;
    logic [`PMS_IDX_W-1:0]     cfg_off;
    logic [`PMS_IDX_W-1:0]     prev_idx;
    logic [`PMS_FLAG_W-1:0]    set_vec;
    logic [15:0]               status_word;
    logic                      mem_we;
    logic [`PMS_IDX_W-1:0]     mem_wa;
    logic [7:0]                mem_wd;
    logic [7:0]                mem_rd;

    pms_nvm #(
        .W     (8),
        .DEPTH (CFG_N),
        .AW    (`PMS_IDX_W),
        .INIT  (`PMS_CFG_DEFAULTS)
    ) u_nvm (
        .sys_clk (sys_clk),
        .wr_en   (mem_we),
        .wr_addr (mem_wa),
        .wr_data (mem_wd),
        .rd_addr (r.idx),
        .rd_data (mem_rd)
    );

    // Status word built from one cycle of state
    always_comb
    begin
        status_word = 16'h0000;
        status_word[`PMS_W_OFF]     = r.s2[`PMS_S_OFF];
        status_word[`PMS_W_VOUT_OV] = r.flags[`PMS_F_OV];
        status_word[`PMS_W_IOUT_OC] = r.flags[`PMS_F_OC];
        status_word[`PMS_W_VIN_UV]  = r.flags[`PMS_F_UV];
        status_word[`PMS_W_TEMP]    = r.flags[`PMS_F_OT];
        status_word[`PMS_W_CML]     = r.flags[`PMS_F_CML];
        status_word[`PMS_W_VOUT]    = r.flags[`PMS_F_VOUT];
        status_word[`PMS_W_IOUT]    = r.flags[`PMS_F_IOUT];
        status_word[`PMS_W_INPUT]   = r.flags[`PMS_F_INPUT];
        status_word[`PMS_W_PG_LOW]  = ~r.s2[`PMS_S_PG];
    end

    // Command decode
    always_comb
    begin
        take     = cmd_valid & r.ready;
        cfg_off8 = cmd_code - `PMS_CMD_CFG_BASE;
        cfg_off  = cfg_off8[`PMS_IDX_W-1:0];
        cfg_hit  = (cmd_code >= `PMS_CMD_CFG_BASE)
                 && (cfg_off8 < 8'(CFG_N));
        unique case (cmd_kind)
            pms_pkg::PMS_SEND:
                unsup = !((cmd_code == `PMS_CMD_CLEAR)
                       || (cmd_code == `PMS_CMD_STORE)
                       || (cmd_code == `PMS_CMD_RESTORE));
            pms_pkg::PMS_RD_WORD:
                unsup = (cmd_code != `PMS_CMD_STAT_WORD);
            pms_pkg::PMS_RD_BYTE:
                unsup = !((cmd_code == `PMS_CMD_STAT_BYTE) || cfg_hit);
            pms_pkg::PMS_WR_BYTE:
                unsup = !cfg_hit;
        endcase
    end

    // Next state
    always_comb
    begin
        n          = r;
        n.rd_valid = 1'b0;
        clr        = 1'b0;
        mem_we     = 1'b0;
        mem_wa     = r.idx;
        mem_wd     = r.op[r.idx];
        prev_idx   = r.idx - `PMS_IDX_W'(1);
        n.s1       = {power_good_pin, cond_conv_off, cond_over_temp,
                      cond_vin_uv, cond_iout_oc, cond_vout_ov};
        n.s2       = r.s1;
        n.en_d     = conv_enable_cmd;
        if (conv_enable_cmd && !r.en_d)
        begin
            clr = 1'b1;
        end
        unique case (r.st)
            pms_pkg::PMS_RUN:
            begin
                if (take && !unsup)
                begin
                    unique case (cmd_kind)
                        pms_pkg::PMS_SEND:
                        begin
                            n.idx = '0;
                            if (cmd_code == `PMS_CMD_CLEAR)
                            begin
                                clr = 1'b1;
                            end
                            else if (cmd_code == `PMS_CMD_STORE)
                            begin
                                n.st = pms_pkg::PMS_STORE;
                            end
                            else
                            begin
                                n.st = pms_pkg::PMS_RESTORE;
                            end
                        end
                        pms_pkg::PMS_WR_BYTE:
                        begin
                            n.op[cfg_off] = cmd_wdata;
                        end
                        pms_pkg::PMS_RD_BYTE:
                        begin
                            n.rd_valid = 1'b1;
                            if (cfg_hit)
                            begin
                                n.rd_data = {8'h00, r.op[cfg_off]};
                            end
                            else
                            begin
                                n.rd_data = {8'h00, status_word[7:0]};
                            end
                        end
                        pms_pkg::PMS_RD_WORD:
                        begin
                            n.rd_valid = 1'b1;
                            n.rd_data  = status_word;
                        end
                    endcase
                end
                else if (take)
                begin
                    // Ignored, but reads still answer so the link never hangs
                    n.rd_valid = (cmd_kind == pms_pkg::PMS_RD_BYTE)
                              || (cmd_kind == pms_pkg::PMS_RD_WORD);
                    n.rd_data  = 16'h0000;
                end
            end
            pms_pkg::PMS_STORE:
            begin
                mem_we = 1'b1;
                if (r.idx == `PMS_IDX_W'(CFG_N - 1))
                begin
                    n.st  = pms_pkg::PMS_RUN;
                    n.idx = '0;
                end
                else
                begin
                    n.idx = r.idx + `PMS_IDX_W'(1);
                end
            end
            pms_pkg::PMS_RESTORE:
            begin
                // Read data lags the address by one cycle
                if (r.idx != '0)
                begin
                    n.op[prev_idx] = mem_rd;
                end
                if (r.idx == `PMS_IDX_W'(CFG_N))
                begin
                    n.st  = pms_pkg::PMS_RUN;
                    n.idx = '0;
                end
                else
                begin
                    n.idx = r.idx + `PMS_IDX_W'(1);
                end
            end
            default:
            begin
                n.st  = pms_pkg::PMS_RUN;
                n.idx = '0;
            end
        endcase
        n.ready = (n.st == pms_pkg::PMS_RUN);

        set_vec = '0;
        set_vec[`PMS_F_OV]    = r.s2[`PMS_S_OV];
        set_vec[`PMS_F_OC]    = r.s2[`PMS_S_OC];
        set_vec[`PMS_F_UV]    = r.s2[`PMS_S_UV];
        set_vec[`PMS_F_OT]    = r.s2[`PMS_S_OT];
        set_vec[`PMS_F_CML]   = take && unsup;
        set_vec[`PMS_F_VOUT]  = r.s2[`PMS_S_OV];
        set_vec[`PMS_F_IOUT]  = r.s2[`PMS_S_OC];
        set_vec[`PMS_F_INPUT] = r.s2[`PMS_S_UV];
        // Set wins over clear, so a standing fault re-sets at once
        n.flags = (clr ? '0 : r.flags) | set_vec;
        n.alert = |n.flags;
    end

    // Bias power-up restores the stored defaults
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            r       <= '0;
            r.st    <= pms_pkg::PMS_RESTORE;
            r.en_d  <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    assign cmd_ready     = r.ready;
    assign rd_valid      = r.rd_valid;
    assign rd_data       = r.rd_data;
    assign alert_pin_out = 1'b0;
    assign alert_pin_oe  = r.alert;
    assign cfg_op        = r.op;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_clear_empties: assert property (
        (take && cmd_kind == pms_pkg::PMS_SEND
         && cmd_code == `PMS_CMD_CLEAR && r.s2[3:0] == 4'h0)
        |=> (r.flags == '0) && !alert_pin_oe)
        else $error("clear-faults left flags or alert set");

    a_clear_rearm: assert property (
        (take && cmd_kind == pms_pkg::PMS_SEND
         && cmd_code == `PMS_CMD_CLEAR && r.s2[`PMS_S_OV])
        |=> r.flags[`PMS_F_OV] && alert_pin_oe)
        else $error("standing fault not re-set after clear");

    a_flag_holds: assert property (
        (r.flags[`PMS_F_OC] && !clr)
        |=> r.flags[`PMS_F_OC])
        else $error("latched flag dropped without a clear");

    a_alert_on_set: assert property (
        r.s1[`PMS_S_OT] |=> ##1 (alert_pin_oe && r.flags[`PMS_F_OT]))
        else $error("fault did not raise alert");

    a_word_raw: assert property (
        (take && cmd_kind == pms_pkg::PMS_RD_WORD
         && cmd_code == `PMS_CMD_STAT_WORD)
        |=> rd_valid
            && rd_data[`PMS_W_OFF] == $past(r.s2[`PMS_S_OFF])
            && rd_data[`PMS_W_PG_LOW] == !$past(r.s2[`PMS_S_PG]))
        else $error("raw status bits wrong in word read");

    a_byte_alias: assert property (
        (take && cmd_kind == pms_pkg::PMS_RD_BYTE
         && cmd_code == `PMS_CMD_STAT_BYTE)
        |=> rd_valid && rd_data == {8'h00, $past(status_word[7:0])})
        else $error("status byte is not the word low byte");

    a_zero_bits: assert property (
        rd_valid && $past(cmd_code) != `PMS_CMD_CFG_BASE
        |-> (rd_data & `PMS_W_ZERO_MASK) == 16'h0000 || $past(cfg_hit))
        else $error("unsupported status bit read as one");

    a_store_busy: assert property (
        (take && !unsup && cmd_kind == pms_pkg::PMS_SEND
         && cmd_code == `PMS_CMD_STORE)
        |=> !cmd_ready [*7] ##1 cmd_ready)
        else $error("store hold-off length wrong");

    a_restore_busy: assert property (
        (take && !unsup && cmd_kind == pms_pkg::PMS_SEND
         && cmd_code == `PMS_CMD_RESTORE)
        |=> !cmd_ready [*8] ##1 cmd_ready)
        else $error("restore hold-off length wrong");

    a_store_copy: assert property (
        (r.st == pms_pkg::PMS_STORE)
        |-> mem_we && mem_wd == r.op[r.idx])
        else $error("store did not copy operating value");

    a_cml_set: assert property (
        (take && unsup) |=> r.flags[`PMS_F_CML] && alert_pin_oe)
        else $error("unsupported command did not flag CML");

    a_summary: assert property (
        r.flags[`PMS_F_OV] |-> r.flags[`PMS_F_VOUT])
        else $error("output voltage summary flag missing");

endmodule

`default_nettype wire

// ---- logic/pms_consts.svh ----
// Command codes, field positions, reset values and sizes of the status block
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH

`define PMS_CMD_CLEAR      8'h03
`define PMS_CMD_STORE      8'h11
`define PMS_CMD_RESTORE    8'h12
`define PMS_CMD_STAT_BYTE  8'h78
`define PMS_CMD_STAT_WORD  8'h79
`define PMS_CMD_CFG_BASE   8'hD0

`define PMS_CFG_N          7
`define PMS_IDX_W          3
`define PMS_CFG_DEFAULTS   56'h00_00_00_02_00_12_00

// Latched flag vector positions
`define PMS_FLAG_W         8
`define PMS_F_OV           0
`define PMS_F_OC           1
`define PMS_F_UV           2
`define PMS_F_OT           3
`define PMS_F_CML          4
`define PMS_F_VOUT         5
`define PMS_F_IOUT         6
`define PMS_F_INPUT        7

// Synchronised condition vector positions
`define PMS_SYNC_W         6
`define PMS_S_OV           0
`define PMS_S_OC           1
`define PMS_S_UV           2
`define PMS_S_OT           3
`define PMS_S_OFF          4
`define PMS_S_PG           5

// Status word bit positions
`define PMS_W_CML          1
`define PMS_W_TEMP         2
`define PMS_W_VIN_UV       3
`define PMS_W_IOUT_OC      4
`define PMS_W_VOUT_OV      5
`define PMS_W_OFF          6
`define PMS_W_PG_LOW       11
`define PMS_W_INPUT        13
`define PMS_W_IOUT         14
`define PMS_W_VOUT         15
`define PMS_W_ZERO_MASK    16'h1781

`endif

// ---- logic/pms_pkg.sv ----
// Types shared by the status and non-volatile command block
`default_nettype none
`include "pms_consts.svh"

package pms_pkg;

    typedef enum logic [1:0] {
        PMS_SEND,
        PMS_WR_BYTE,
        PMS_RD_BYTE,
        PMS_RD_WORD
    } pms_kind_t;

    typedef enum logic [1:0] {
        PMS_RUN,
        PMS_STORE,
        PMS_RESTORE
    } pms_state_t;

    typedef struct packed {
        pms_state_t                      st;
        logic [`PMS_IDX_W-1:0]           idx;
        logic [`PMS_CFG_N-1:0][7:0]      op;
        logic [`PMS_FLAG_W-1:0]          flags;
        logic [`PMS_SYNC_W-1:0]          s1;
        logic [`PMS_SYNC_W-1:0]          s2;
        logic                            en_d;
        logic                            ready;
        logic                            rd_valid;
        logic [15:0]                     rd_data;
        logic                            alert;
    } pms_regs_t;

endpackage

`default_nettype wire

// ---- logic/pms_nvm.sv ----
// Non-volatile configuration cells with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.svh"

module pms_nvm #(
    parameter int          W     = 8,
    parameter int          DEPTH = `PMS_CFG_N,
    parameter int          AW    = `PMS_IDX_W,
    parameter [DEPTH*W-1:0] INIT = `PMS_CFG_DEFAULTS
) (
    input  wire logic          sys_clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output var  logic [W-1:0]  rd_data
);

    logic [W-1:0] cells [DEPTH];

    // Cells survive bias cycling, so they carry no reset; preload = factory
    initial
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            cells[i] = INIT[i*W +: W];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (wr_en)
        begin
            cells[wr_addr] <= wr_data;
        end
        rd_data <= cells[rd_addr];
    end

endmodule

`default_nettype wire

// ---- tb/pms_host.sv ----
// Host controller model driving the command port of the status block
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.svh"

module pms_host (
    input  wire logic               sys_clk,
    input  wire logic               cmd_ready,
    input  wire logic               rd_valid,
    input  wire logic [15:0]        rd_data,
    output var  logic               cmd_valid,
    output var  pms_pkg::pms_kind_t cmd_kind,
    output var  logic [7:0]         cmd_code,
    output var  logic [7:0]         cmd_wdata
);
    localparam int STORE_LIMIT = 1000;
    int n_store = 0;
    int n_hang = 0;

    initial
    begin
        cmd_valid = 1'b0;
        cmd_kind  = pms_pkg::PMS_SEND;
        cmd_code  = 8'h00;
        cmd_wdata = 8'h00;
    end

    // Holds the request until a cycle with ready high, then takes the answer
    task automatic xfer(input pms_pkg::pms_kind_t k, input logic [7:0] c,
                        input logic [7:0] d, output logic [15:0] r,
                        output logic rv);
        int n;
        @(posedge sys_clk);
        #1;
        if (k == pms_pkg::PMS_SEND && c == `PMS_CMD_STORE)
        begin
            n_store++;
            if (n_store > STORE_LIMIT)
                $display("host: store budget exceeded");
        end
        cmd_valid = 1'b1;
        cmd_kind  = k;
        cmd_code  = c;
        cmd_wdata = d;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 40)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 40)
            n_hang++;
        @(posedge sys_clk);
        #1;
        rv        = rd_valid;
        r         = rd_data;
        cmd_valid = 1'b0;
        cmd_code  = ~c;
        cmd_wdata = ~d;
    endtask
endmodule

`default_nettype wire

// ---- tb/pms_status_tb.sv ----
// Self-checking bench of the status and non-volatile command block
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.svh"

module pms_status_tb;
    logic               sys_clk = 1'b0;
    logic               rst = 1'b1;
    logic               cmd_valid;
    logic               cmd_ready;
    pms_pkg::pms_kind_t cmd_kind;
    logic [7:0]         cmd_code;
    logic [7:0]         cmd_wdata;
    logic               rd_valid;
    logic [15:0]        rd_data;
    logic [3:0]         cnd = 4'h0;
    logic               off_c = 1'b0;
    logic               pg = 1'b1;
    logic               en = 1'b1;
    logic               alert_pin_out;
    logic               alert_pin_oe;
    logic [55:0]        cfg_op;
    logic [4:0]         flg = 5'h00;
    logic [31:0]        seed = 32'h5C81;
    int                 cfg_m[7];
    int                 nvm_m[7];
    int                 error_cnt = 0;
    int                 n_compared = 0;
    int                 cyc = 0;
    logic [15:0]        r;
    logic               rv;

    always #2 sys_clk = ~sys_clk;

    pms_status dut (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .rd_valid(rd_valid), .rd_data(rd_data),
        .cond_vout_ov(cnd[0]), .cond_iout_oc(cnd[1]), .cond_vin_uv(cnd[2]),
        .cond_over_temp(cnd[3]), .cond_conv_off(off_c),
        .power_good_pin(pg), .conv_enable_cmd(en),
        .alert_pin_out(alert_pin_out), .alert_pin_oe(alert_pin_oe),
        .cfg_op(cfg_op));

    pms_host u_host (.sys_clk(sys_clk), .cmd_ready(cmd_ready),
        .rd_valid(rd_valid), .rd_data(rd_data), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return (s >> 1) ^ (s[0] ? 32'h80200003 : 32'h00000000);
    endfunction

    function automatic logic [15:0] exp_word();
        logic [15:0] w;
        w = 16'h0000;
        w[5] = flg[0];
        w[4] = flg[1];
        w[3] = flg[2];
        w[2] = flg[3];
        w[1] = flg[4];
        w[15] = flg[0];
        w[14] = flg[1];
        w[13] = flg[2];
        w[6] = off_c;
        w[11] = ~pg;
        return w;
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t %s: got %h want %h", $time, what, seen,
                     exp);
        end
    endtask

    task automatic wrap_up();
        error_cnt += u_host.n_hang;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Lets synchronisers and latches settle, then folds conditions in
    task automatic settle();
        repeat (4) @(posedge sys_clk);
        #1;
        flg[3:0] = flg[3:0] | cnd;
    endtask

    // Host reacts to the alert line instead of polling status
    task automatic wait_alert();
        int n;
        n = 0;
        while (alert_pin_oe !== 1'b1 && n < 10)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk(16'(n), 16'h0003, "alert latency");
    endtask

    task automatic send(input logic [7:0] c);
        u_host.xfer(pms_pkg::PMS_SEND, c, 8'h00, r, rv);
    endtask

    task automatic check_status();
        logic [15:0] e;
        e = exp_word();
        u_host.xfer(pms_pkg::PMS_RD_WORD, `PMS_CMD_STAT_WORD, 8'h00, r, rv);
        chk({15'h0000, rv}, 16'h0001, "word answer");
        chk(r, e, "status word");
        chk(r & 16'h1781, 16'h0000, "unused bits");
        u_host.xfer(pms_pkg::PMS_RD_BYTE, `PMS_CMD_STAT_BYTE, 8'h00, r, rv);
        chk(r, {8'h00, e[7:0]}, "status byte");
        chk({15'h0000, alert_pin_oe}, {15'h0000, |flg}, "alert");
        chk({15'h0000, alert_pin_out}, 16'h0000, "alert level");
        for (int i = 0; i < 7; i++)
            chk({8'h00, cfg_op[8*i+:8]}, 16'(cfg_m[i]), "config");
    endtask

    task automatic fill_cfg();
        for (int i = 0; i < 7; i++)
        begin
            seed = lfsr(seed);
            cfg_m[i] = int'(seed[7:0]);
            u_host.xfer(pms_pkg::PMS_WR_BYTE, 8'hD0 + 8'(i), seed[7:0], r, rv);
            u_host.xfer(pms_pkg::PMS_RD_BYTE, 8'hD0 + 8'(i), 8'h00, r, rv);
            chk(r, {8'h00, seed[7:0]}, "config read back");
        end
    endtask

    task automatic busy_len(input int exp);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 20)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk(16'(n), 16'(exp), "copy busy cycles");
    endtask

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    initial
    begin
        for (int i = 0; i < 7; i++)
            nvm_m[i] = int'(8'(`PMS_CFG_DEFAULTS >> (8 * i)));
        cfg_m = nvm_m;
        repeat (20) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        check_status();
        for (int i = 0; i < 4; i++)
        begin
            {off_c, pg} = 2'(i);
            settle();
            check_status();
        end
        // Each fault: latch; even ones held after removal and cleared absent, odd ones cleared present; then all cleared absent
        for (int i = 0; i < 4; i++)
        begin
            cnd[i] = 1'b1;
            wait_alert();
            settle();
            check_status();
            cnd[i] = i[0];
            settle();
            check_status();
            send(`PMS_CMD_CLEAR);
            flg = {1'b0, cnd};
            settle();
            check_status();
            cnd[i] = 1'b0;
            settle();
            send(`PMS_CMD_CLEAR);
            flg = 5'h00;
            settle();
            check_status();
        end
        // Unsupported commands, then clear by off-then-on
        send(8'h55);
        u_host.xfer(pms_pkg::PMS_WR_BYTE, `PMS_CMD_STAT_BYTE, 8'hA5, r, rv);
        u_host.xfer(pms_pkg::PMS_RD_BYTE, 8'h40, 8'h00, r, rv);
        chk({rv, r[14:0]}, 16'h8000, "unsupported read");
        u_host.xfer(pms_pkg::PMS_RD_WORD, `PMS_CMD_STAT_BYTE, 8'h00, r, rv);
        chk({rv, r[14:0]}, 16'h8000, "unsupported word read");
        flg[4] = 1'b1;
        settle();
        check_status();
        en = 1'b0;
        settle();
        check_status();
        en = 1'b1;
        flg = 5'h00;
        settle();
        check_status();
        // Store, restore and defaults after a bias cycle
        off_c = 1'b0;
        fill_cfg();
        send(`PMS_CMD_STORE);
        busy_len(7);
        nvm_m = cfg_m;
        fill_cfg();
        check_status();
        send(`PMS_CMD_RESTORE);
        busy_len(8);
        cfg_m = nvm_m;
        check_status();
        fill_cfg();
        cnd[1] = 1'b1;
        settle();
        cnd[1] = 1'b0;
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        cfg_m = nvm_m;
        flg = 5'h00;
        check_status();
        wrap_up();
    end
endmodule

`default_nettype wire
